//--- common/wdt_pkg.sv
// Shared constants, field layouts and types for the windowed watchdog
package wdt_pkg;

   // ----------------------------------------------------------------
   // APB register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] WDT_ADDR_CFG = 8'h00;
   localparam logic [7:0] WDT_ADDR_STATUS = 8'h04;
   localparam logic [7:0] WDT_ADDR_COUNT = 8'h08;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   // Configuration word
   localparam int WDT_CFG_POST_LSB = 0;
   localparam int WDT_CFG_POST_W = 4;
   localparam int WDT_CFG_PRE_BIT = 4;
   localparam int WDT_CFG_WINDOW_DISABLE_BIT = 6;
   localparam int WDT_CFG_ALWAYS_BIT = 7;
   // Reset control status word
   localparam int WDT_ST_IDLE_BIT = 2;
   localparam int WDT_ST_SLEEP_BIT = 3;
   localparam int WDT_ST_TIMEOUT_BIT = 4;
   localparam int WDT_ST_SOFT_EN_BIT = 5;

   // ----------------------------------------------------------------
   // Timing: prescaler periods in low-power RC oscillator cycles
   // ----------------------------------------------------------------
   localparam int WDT_LOW_POWER_RC_OSC_FREQ_HZ = 32000;
   localparam int WDT_PRE_TIME_LO_US = 1000;
   localparam int WDT_PRE_TIME_HI_US = 4000;
   localparam int WDT_PRE_DIV_LO = WDT_LOW_POWER_RC_OSC_FREQ_HZ / 1000 * WDT_PRE_TIME_LO_US / 1000;
   localparam int WDT_PRE_DIV_HI = WDT_LOW_POWER_RC_OSC_FREQ_HZ / 1000 * WDT_PRE_TIME_HI_US / 1000;
   // Shift from postscale code to quarter-period exponent, per prescaler
   localparam logic [4:0] WDT_QTR_SHIFT_LO = 5'd3;
   localparam logic [4:0] WDT_QTR_SHIFT_HI = 5'd5;

   // ----------------------------------------------------------------
   // Counter widths
   // ----------------------------------------------------------------
   localparam int WDT_PRE_W = 7;
   localparam int WDT_POST_W = 15;
   localparam int WDT_ELAPSED_W = 22;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // Watchdog configuration word
   typedef struct packed {
      logic always_on_cfg;
      logic window_disable;
      logic prescale_select;
      logic [3:0] postscale_select;
   } wdt_cfg_t;

   // Requests from the processor core and reset/clock logic
   typedef struct packed {
      logic wd_clear_instr;
      logic power_save_instr;
      logic power_save_idle;
      logic clk_switch_done;
      logic device_reset;
      logic wake_other;
   } wdt_core_req_t;

   // Power state seen by the watchdog
   typedef enum logic [2:0] {
      WDT_ST_RUN = 3'b001,
      WDT_ST_SLEEP = 3'b010,
      WDT_ST_IDLE = 3'b100
   } wdt_state_t;

   // Unprogrammed configuration reads as ones
   localparam wdt_cfg_t WDT_CFG_RESET = '{1'b1, 1'b1, 1'b1, 4'hf};

endpackage

//--- rtl/wdt_tick_sync.sv
// Synchroniser and edge detector turning the RC oscillator into ticks
`timescale 1ns/1ns
`default_nettype none
module wdt_tick_sync (
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic low_power_rc_osc_clk_i,
   output logic tick_o
);

   // ----------------------------------------------------------------
   // Two-flop synchroniser, then a rising edge detector
   // ----------------------------------------------------------------
   logic meta_reg; // First stage, read only by the second
   logic sync_reg; // Safe copy of the oscillator level
   logic prev_reg; // Last safe level, for edge detection

   // Oscillator is asynchronous to the system clock
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
         tick_o <= 1'b0;
      end
      else
      begin
         meta_reg <= low_power_rc_osc_clk_i;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
         tick_o <= sync_reg & ~prev_reg;
      end
   end

endmodule
`default_nettype wire

//--- rtl/wdt_windowed.sv
// Windowed watchdog timer with APB registers and power-save wake-up
//
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module wdt_windowed
   import wdt_pkg::*;
(
   input wire logic clock_i,
   input wire logic reset_n_i,
   input wire logic low_power_rc_osc_clk_i,
   input wire wdt_core_req_t core_req_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic wdt_reset_o,
   output logic wake_o,
   output logic low_power_rc_osc_enable_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wdt_cfg_t cfg_reg; // Configuration word
   wdt_state_t state_reg; // Run, sleep or idle
   logic soft_wd_enable_reg; // Software enable
   logic timeout_flag_reg; // Sticky time-out flag
   logic sleep_flag_reg; // Sticky sleep flag
   logic idle_flag_reg; // Sticky idle flag
   logic [WDT_PRE_W-1:0] pre_cnt_reg; // Prescaler count
   logic [WDT_POST_W-1:0] post_cnt_reg; // Postscaler count
   logic tick; // One pulse per oscillator cycle
   logic wd_active; // Watchdog enabled
   logic [WDT_PRE_W-1:0] pre_lim; // Last prescaler count
   logic [WDT_POST_W-1:0] post_lim; // Last postscaler count
   logic pre_term; // Prescaler at its last count
   logic post_term; // Postscaler at its last count
   logic expire; // Full period elapsed on this tick
   logic [WDT_ELAPSED_W-1:0] elapsed; // Ticks since restart
   logic [WDT_ELAPSED_W-1:0] win_start; // First tick of last quarter
   logic early_clear; // Clear before the window opens
   logic trip; // Watchdog device reset request
   logic power_save_instr_take; // Power-save entry accepted
   logic ps_exit; // Leaving sleep or idle
   logic restart; // Clear all counts
   logic apb_setup; // First access cycle, answer computed
   logic apb_wr; // Write completes at this edge
   logic st_wr; // Write to status completes
   logic cfg_wr; // Write to configuration completes
   logic [31:0] rd_data; // Read mux
   logic rd_err; // Unmapped address

   // ----------------------------------------------------------------
   // Oscillator ticks
   // ----------------------------------------------------------------
   // Counting is on oscillator edges, never on raw system cycles
   wdt_tick_sync u_tick_sync (
      .clock_i(clock_i),
      .reset_n_i(reset_n_i),
      .low_power_rc_osc_clk_i(low_power_rc_osc_clk_i),
      .tick_o(tick)
   );

   // ----------------------------------------------------------------
   // Period decode and window check
   // ----------------------------------------------------------------
   // Enable: configuration bit dominates the software bit
   assign wd_active = cfg_reg.always_on_cfg | soft_wd_enable_reg;
   // Prescaler length, one means the long setting
   assign pre_lim = cfg_reg.prescale_select ? WDT_PRE_W'(WDT_PRE_DIV_HI - 1)
                                            : WDT_PRE_W'(WDT_PRE_DIV_LO - 1);
   // Postscaler ratio is a power of two of the code
   assign post_lim = WDT_POST_W'((32'h1 << cfg_reg.postscale_select) - 32'h1);
   assign pre_term = (pre_cnt_reg == pre_lim);
   assign post_term = (post_cnt_reg == post_lim);
   // Period is the product of both ratios in oscillator ticks
   assign expire = tick & wd_active & pre_term & post_term;
   // Ticks so far, packing the postscaler above the prescaler
   assign elapsed = cfg_reg.prescale_select ? {post_cnt_reg, pre_cnt_reg}
                                            : {2'b00, post_cnt_reg, pre_cnt_reg[4:0]};
   // Three quarters of the period, where the clear window opens
   assign win_start = WDT_ELAPSED_W'(32'h3 << (cfg_reg.postscale_select
      + (cfg_reg.prescale_select ? WDT_QTR_SHIFT_HI : WDT_QTR_SHIFT_LO)));
   // Only an enabled, windowed watchdog punishes an early clear
   assign early_clear = (state_reg == WDT_ST_RUN) & core_req_i.wd_clear_instr & wd_active
                        & ~cfg_reg.window_disable & (elapsed < win_start);
   // Device reset comes from a running time-out or an early clear
   assign trip = ((state_reg == WDT_ST_RUN) & expire) | early_clear;
   assign power_save_instr_take = (state_reg == WDT_ST_RUN) & core_req_i.power_save_instr & ~trip;
   assign ps_exit = (state_reg != WDT_ST_RUN) & (expire | core_req_i.wake_other);

   // ----------------------------------------------------------------
   // Counter restart
   // ----------------------------------------------------------------
   // A configuration write also restarts, so no count overshoots its limit
   assign restart = core_req_i.device_reset | core_req_i.clk_switch_done | power_save_instr_take
                    | ps_exit | trip | ~wd_active | cfg_wr
                    | ((state_reg == WDT_ST_RUN) & core_req_i.wd_clear_instr);

   // ----------------------------------------------------------------
   // Prescaler and postscaler
   // ----------------------------------------------------------------
   // Counts in every power state while enabled
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pre_cnt_reg <= '0;
         post_cnt_reg <= '0;
      end
      else if (restart)
      begin
         pre_cnt_reg <= '0;
         post_cnt_reg <= '0;
      end
      else if (tick)
      begin
         if (pre_term)
         begin
            pre_cnt_reg <= '0;
            post_cnt_reg <= post_term ? '0 : post_cnt_reg + 1'b1;
         end
         else
         begin
            pre_cnt_reg <= pre_cnt_reg + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Power state
   // ----------------------------------------------------------------
   // Tracks sleep and idle so a time-out there wakes instead of resetting
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         state_reg <= WDT_ST_RUN;
      else if (core_req_i.device_reset)
         state_reg <= WDT_ST_RUN;
      else
      begin
         case (state_reg)
            WDT_ST_RUN:
            begin
               if (power_save_instr_take)
                  state_reg <= core_req_i.power_save_idle ? WDT_ST_IDLE : WDT_ST_SLEEP;
            end
            WDT_ST_SLEEP, WDT_ST_IDLE:
            begin
               if (ps_exit)
                  state_reg <= WDT_ST_RUN;
            end
            default:
               state_reg <= WDT_ST_RUN;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Event outputs
   // ----------------------------------------------------------------
   // Reset and wake are one-cycle pulses, the oscillator enable is a level; the core resumes after its power-save instruction
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wdt_reset_o <= 1'b0;
         wake_o <= 1'b0;
         low_power_rc_osc_enable_o <= 1'b0;
      end
      else
      begin
         wdt_reset_o <= trip;
         wake_o <= (state_reg != WDT_ST_RUN) & expire & ~core_req_i.device_reset;
         low_power_rc_osc_enable_o <= wd_active;
      end
   end

   // ----------------------------------------------------------------
   // Status bits
   // ----------------------------------------------------------------
   // Writing zero clears a flag; a set in the same cycle wins
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         soft_wd_enable_reg <= 1'b0;
         timeout_flag_reg <= 1'b0;
         sleep_flag_reg <= 1'b0;
         idle_flag_reg <= 1'b0;
      end
      else
      begin
         // Our own trip is a device reset too
         if (core_req_i.device_reset | trip)
            soft_wd_enable_reg <= 1'b0;
         else if (st_wr)
            soft_wd_enable_reg <= pwdata_i[WDT_ST_SOFT_EN_BIT];
         if (expire | early_clear)
            timeout_flag_reg <= 1'b1;
         else if (st_wr & ~pwdata_i[WDT_ST_TIMEOUT_BIT])
            timeout_flag_reg <= 1'b0;
         // Wake-up leaves these set for software
         if (power_save_instr_take & ~core_req_i.power_save_idle)
            sleep_flag_reg <= 1'b1;
         else if (st_wr & ~pwdata_i[WDT_ST_SLEEP_BIT])
            sleep_flag_reg <= 1'b0;
         if (power_save_instr_take & core_req_i.power_save_idle)
            idle_flag_reg <= 1'b1;
         else if (st_wr & ~pwdata_i[WDT_ST_IDLE_BIT])
            idle_flag_reg <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   // One wait state: pready rises in the second access cycle
   assign apb_setup = psel_i & penable_i & ~pready_o;
   assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
   assign st_wr = apb_wr & (paddr_i == WDT_ADDR_STATUS);
   assign cfg_wr = apb_wr & (paddr_i == WDT_ADDR_CFG);

   // Read mux; unused upper bits read zero
   always_comb
   begin
      rd_data = 32'h0;
      rd_err = 1'b0;
      case (paddr_i)
         WDT_ADDR_CFG:
         begin
            rd_data[WDT_CFG_ALWAYS_BIT] = cfg_reg.always_on_cfg;
            rd_data[WDT_CFG_WINDOW_DISABLE_BIT] = cfg_reg.window_disable;
            rd_data[WDT_CFG_PRE_BIT] = cfg_reg.prescale_select;
            rd_data[WDT_CFG_POST_LSB +: WDT_CFG_POST_W] = cfg_reg.postscale_select;
         end
         WDT_ADDR_STATUS:
         begin
            rd_data[WDT_ST_SOFT_EN_BIT] = soft_wd_enable_reg;
            rd_data[WDT_ST_TIMEOUT_BIT] = timeout_flag_reg;
            rd_data[WDT_ST_SLEEP_BIT] = sleep_flag_reg;
            rd_data[WDT_ST_IDLE_BIT] = idle_flag_reg;
         end
         WDT_ADDR_COUNT:
            rd_data[WDT_ELAPSED_W-1:0] = elapsed;
         default:
            rd_err = 1'b1;
      endcase
   end

   // Answer registers, valid only while pready is high
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o <= apb_setup;
         prdata_o <= (apb_setup & ~pwrite_i) ? rd_data : 32'h0;
         pslverr_o <= apb_setup & rd_err;
      end
   end

   // Configuration word, steering the counters
   always_ff @(posedge clock_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         cfg_reg <= WDT_CFG_RESET;
      else if (cfg_wr)
         cfg_reg <= '{pwdata_i[WDT_CFG_ALWAYS_BIT], pwdata_i[WDT_CFG_WINDOW_DISABLE_BIT],
                      pwdata_i[WDT_CFG_PRE_BIT],
                      pwdata_i[WDT_CFG_POST_LSB +: WDT_CFG_POST_W]};
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_low_power_rc_osc_enable_follow: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (cfg_reg.always_on_cfg | soft_wd_enable_reg) |=> low_power_rc_osc_enable_o)
      else $error("oscillator not enabled while watchdog enabled");

   a_pre_short_limit: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !cfg_reg.prescale_select |-> pre_cnt_reg <= 7'd31)
      else $error("short prescaler exceeded 32 counts");

   a_clear_restarts: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (state_reg == WDT_ST_RUN && core_req_i.wd_clear_instr)
      |=> (pre_cnt_reg == 7'd0 && post_cnt_reg == 15'd0))
      else $error("clear did not restart counts");

   a_power_save_instr_enters: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (power_save_instr_take && !core_req_i.device_reset)
      |=> (state_reg != WDT_ST_RUN && pre_cnt_reg == 7'd0 && post_cnt_reg == 15'd0))
      else $error("power-save entry did not restart");

   a_window_early: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      early_clear |=> (wdt_reset_o && timeout_flag_reg))
      else $error("early clear did not reset device");

   a_run_timeout: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (state_reg == WDT_ST_RUN && expire) |=> (wdt_reset_o && timeout_flag_reg && !wake_o))
      else $error("run time-out did not reset device");

   a_sleep_wakes: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (state_reg != WDT_ST_RUN && expire && !core_req_i.device_reset)
      |=> (wake_o && !wdt_reset_o && state_reg == WDT_ST_RUN))
      else $error("power-save time-out did not wake");

   a_flags_after_wake: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (state_reg == WDT_ST_SLEEP && sleep_flag_reg && expire && !st_wr) |=> sleep_flag_reg)
      else $error("sleep flag lost at wake-up");

   a_timeout_sticky: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      (timeout_flag_reg && !st_wr) |=> timeout_flag_reg)
      else $error("time-out flag dropped without software");

   a_soft_en_reset: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      core_req_i.device_reset |=> !soft_wd_enable_reg)
      else $error("device reset left software enable set");

   a_disabled_held: assert property (@(posedge clock_i) disable iff (!reset_n_i)
      !wd_active |=> (pre_cnt_reg == 7'd0 && post_cnt_reg == 15'd0 && !wdt_reset_o))
      else $error("disabled watchdog counted");

endmodule
`default_nettype wire

//--- verification/wdt_core_model.sv
// Behavioural processor core that issues watchdog requests
`timescale 1ns/1ns
`default_nettype none
module wdt_core_model
   import wdt_pkg::*;
(
   input wire logic clock_i,
   input wire logic wake_i,
   output logic [5:0] core_req_o,
   output logic asleep_o
);
   // ----------------------------------------------------------------
   // Request pulses
   // ----------------------------------------------------------------
   // One-cycle pulse; the idle qualifier rides along with the request
   task automatic pulse(input wdt_core_req_t r);
      @(posedge clock_i);
      core_req_o <= r;
      if (r.power_save_instr)
         asleep_o <= 1'b1;
      @(posedge clock_i);
      core_req_o <= '0;
   endtask
   // Execution resumes after the power-save request once woken
   always @(posedge clock_i)
   begin
      if (wake_i === 1'b1)
         asleep_o <= 1'b0;
   end
   // Quiet core at time zero
   initial
   begin
      core_req_o = '0;
      asleep_o = 1'b0;
   end
endmodule
`default_nettype wire

//--- verification/wdt_windowed_tb.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
module wdt_windowed_tb;
   import wdt_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clock_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic low_power_rc_osc_clk_i = 1'b0; // Fast stand-in oscillator, 8 clocks a tick
   logic [5:0] core_req;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, wdt_reset, wake, low_power_rc_osc_en, asleep, hit;
   logic [31:0] rd;
   logic err;
   int errors = 0;
   int samples_checked = 0;
   int cycles = 0;
   int ticks = 0;
   int n_rst = 0;
   int t0, r0;
   logic [7:0] cfgs [3] = '{8'hc0, 8'hd1, 8'hc3};
   int lens [3] = '{32, 256, 256};

   wdt_windowed i_wdt_windowed (.clock_i(clock_i), .reset_n_i(reset_n_i),
      .low_power_rc_osc_clk_i(low_power_rc_osc_clk_i), .core_req_i(core_req), .paddr_i(paddr),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .wdt_reset_o(wdt_reset), .wake_o(wake), .low_power_rc_osc_enable_o(low_power_rc_osc_en));
   wdt_core_model i_wdt_core_model (.clock_i(clock_i), .wake_i(wake),
      .core_req_o(core_req), .asleep_o(asleep));

   // ----------------------------------------------------------------
   // Clocks, tick and event counters, hang guard
   // ----------------------------------------------------------------
   always #2 clock_i = ~clock_i;
   always #16 low_power_rc_osc_clk_i = ~low_power_rc_osc_clk_i;
   always @(posedge low_power_rc_osc_clk_i) ticks++;
   // Whole run needs about 8000 cycles
   always @(posedge clock_i)
   begin
      cycles++;
      if (wdt_reset === 1'b1)
         n_rst++;
      if (cycles == 30000)
      begin
         errors++;
         give_verdict();
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Tick count within one tick of the expected figure
   task automatic near(input int d, input int exp);
      chk(32'(d >= exp - 1 && d <= exp + 1), 32'h1);
   endtask
   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      // No fixed wait assumed; only the hang guard ends a stuck transfer
      do
         @(posedge clock_i);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Wait for a reset or wake pulse, bounded
   task automatic wait_pin(input bit use_wake, input int lim);
      int n;
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
         hit = use_wake ? wake : wdt_reset;
      end
      while (hit !== 1'b1 && n < lim);
   endtask
   task automatic wait_ticks(input int k);
      int t;
      t = ticks;
      while (ticks - t < k)
         @(posedge clock_i);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clock_i);
      reset_n_i <= 1'b1;
      // Reset state and an unmapped place
      apb(1'b0, WDT_ADDR_CFG, 32'h0);
      chk(rd, 32'h000000df);
      chk(low_power_rc_osc_en, 1'b1);
      apb(1'b0, WDT_ADDR_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      $display("test reset done");
      // Period from prescaler and postscaler while running
      for (int i = 0; i < 3; i++)
      begin
         apb(1'b1, WDT_ADDR_CFG, {24'h0, cfgs[i]});
         t0 = ticks;
         wait_pin(1'b0, lens[i] * 8 + 40);
         chk(hit, 1'b1);
         near(ticks - t0, lens[i]);
         apb(1'b0, WDT_ADDR_STATUS, 32'h0);
         chk(rd[4], 1'b1);
      end
      apb(1'b1, WDT_ADDR_STATUS, 32'h0);
      apb(1'b0, WDT_ADDR_STATUS, 32'h0);
      chk(rd[4], 1'b0);
      $display("test periods done");
      // Regular clears keep the device alive
      apb(1'b1, WDT_ADDR_CFG, 32'hc0);
      r0 = n_rst;
      repeat (6)
      begin
         wait_ticks(16);
         i_wdt_core_model.pulse(6'h20);
      end
      chk(n_rst - r0, 0);
      // Clock switch completion restarts the count
      wait_ticks(20);
      i_wdt_core_model.pulse(6'h04);
      t0 = ticks;
      wait_pin(1'b0, 400);
      near(ticks - t0, 32);
      $display("test clears done");
      // Window mode: early clear trips, late clear does not
      apb(1'b1, WDT_ADDR_CFG, 32'h80);
      wait_ticks(4);
      r0 = n_rst;
      i_wdt_core_model.pulse(6'h20);
      repeat (4) @(posedge clock_i);
      chk(n_rst - r0, 1);
      apb(1'b1, WDT_ADDR_CFG, 32'h80);
      wait_ticks(27);
      r0 = n_rst;
      i_wdt_core_model.pulse(6'h20);
      repeat (4) @(posedge clock_i);
      chk(n_rst - r0, 0);
      $display("test window done");
      // Sleep then idle: wake without reset, flags left set
      for (int idle = 0; idle < 2; idle++)
      begin
         apb(1'b1, WDT_ADDR_CFG, 32'hc0);
         wait_ticks(10);
         r0 = n_rst;
         i_wdt_core_model.pulse({2'b01, idle[0], 3'b000});
         t0 = ticks;
         wait_pin(1'b1, 400);
         chk(hit, 1'b1);
         near(ticks - t0, 32);
         repeat (2) @(posedge clock_i);
         chk(n_rst - r0, 0);
         chk(asleep, 1'b0);
         apb(1'b0, WDT_ADDR_STATUS, 32'h0);
         chk(rd[5:2], idle ? 4'h5 : 4'h6);
         apb(1'b1, WDT_ADDR_STATUS, 32'h0);
      end
      // Leaving sleep by another wake source also restarts the count
      apb(1'b1, WDT_ADDR_CFG, 32'hc0);
      wait_ticks(10);
      i_wdt_core_model.pulse(6'h10);
      wait_ticks(10);
      i_wdt_core_model.pulse(6'h01);
      t0 = ticks;
      wait_pin(1'b0, 400);
      near(ticks - t0, 32);
      $display("test power save done");
      // Software enable with always-on cleared
      apb(1'b1, WDT_ADDR_CFG, 32'h40);
      r0 = n_rst;
      wait_ticks(40);
      chk(low_power_rc_osc_en, 1'b0);
      chk(n_rst - r0, 0);
      apb(1'b1, WDT_ADDR_STATUS, 32'h20);
      t0 = ticks;
      wait_pin(1'b0, 400);
      near(ticks - t0, 32);
      apb(1'b0, WDT_ADDR_STATUS, 32'h0);
      chk(rd[5], 1'b0);
      apb(1'b1, WDT_ADDR_STATUS, 32'h20);
      i_wdt_core_model.pulse(6'h02);
      apb(1'b0, WDT_ADDR_STATUS, 32'h0);
      chk(rd[5], 1'b0);
      $display("test soft enable done");
      give_verdict();
   end
endmodule
`default_nettype wire
